// file: testbench/external_oscillator_control_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module external_oscillator_control_monitor (
  // Bus
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic [7:0] sfr_page_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic       sfr_wr_in,
  input wire logic       sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic       sfr_sel_out,
  // Fields
  input wire logic [2:0] ext_osc_mode_select_out,
  input wire logic [2:0] ext_osc_range_control_out,
  input wire logic       osc_enable_out,
  input wire logic       crystal_drive_en_out,
  input wire logic       div2_en_out,
  input wire logic       crystal_valid_flag_out
);
  wire logic hit = sfr_addr_in == 8'h9F && sfr_page_in == 8'h0F;
  logic [2:0] mode_ff;
  always_ff @(posedge clk_in) mode_ff <= ext_osc_mode_select_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_sel_on_hit: assert property (hit && (sfr_wr_in || sfr_rd_in) |=> sfr_sel_out)
    else $error("no select after hit");
  a_sel_on_miss: assert property (!hit |=> !sfr_sel_out)
    else $error("select after miss");
  a_bit3_zero: assert property (!sfr_rdata_out[3]) else $error("bit 3 set");
  a_read_image: assert property (hit && sfr_rd_in |=> sfr_rdata_out[6:4] == $past(ext_osc_mode_select_out)
    && sfr_rdata_out[7] == $past(crystal_valid_flag_out)
    && sfr_rdata_out[2:0] == $past(ext_osc_range_control_out)) else $error("read image wrong");
  a_write_fields: assert property (hit && sfr_wr_in |=> ext_osc_range_control_out == $past(sfr_wdata_in[2:0])
    && ext_osc_mode_select_out == $past(sfr_wdata_in[6:4])) else $error("write lost");
  a_fields_hold: assert property (!(hit && sfr_wr_in) |=> $stable(ext_osc_mode_select_out)
    && $stable(ext_osc_range_control_out)) else $error("field changed");
  a_enable_map: assert property (osc_enable_out == (mode_ff[2:1] != 2'h0) && div2_en_out ==
    (mode_ff[1:0] == 2'h3) && crystal_drive_en_out == (mode_ff[2:1] == 2'h3)) else $error("enable map");
  a_valid_off: assert property (ext_osc_mode_select_out[2:1] != 2'h3 [*2] |-> !crystal_valid_flag_out)
    else $error("valid outside crystal mode");
  a_valid_rise: assert property ($rose(crystal_valid_flag_out) |-> crystal_drive_en_out)
    else $error("valid without crystal");
endmodule
bind external_oscillator_control external_oscillator_control_monitor u_mon (.*);
`default_nettype wire

// file: testbench/test_external_oscillator_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_external_oscillator_control;
  logic       clk_in = 0;
  logic       rst_n_in = 0;
  logic [7:0] sfr_page_in = 8'h0F;
  logic [7:0] sfr_addr_in = 8'h9F;
  logic       sfr_wr_in = 0;
  logic       sfr_rd_in = 0;
  logic [7:0] sfr_wdata_in = 8'h00;
  logic       crystal_input_pin_in;
  logic [7:0] sfr_rdata_out;
  logic       sfr_sel_out, osc_enable_out, crystal_drive_en_out, div2_en_out;
  logic       crystal_valid_flag_out;
  logic [2:0] ext_osc_mode_select_out, ext_osc_range_control_out;
  int         n_errors = 0;
  int         checked = 0;
  // Written byte, expected read-back, expected {osc, drive, div2} enables
  logic [19:0] rows [8] = '{20'h08000, 20'h11110, 20'h22224, 20'h33335, 20'h44444,
                            20'h55554, 20'h6E666, 20'hFF777};
  external_oscillator_control #(.STABLE_EDGES(4)) u_external_oscillator_control (.*);
  xtal_model u_xtal_model (.drive_en_in(crystal_drive_en_out), .pin_out(crystal_input_pin_in));
  always #5 clk_in = ~clk_in;
  task bus(input logic [7:0] wd, input logic w, input logic r);
    @(posedge clk_in);
    #1 sfr_wdata_in = wd;
    sfr_wr_in = w;
    sfr_rd_in = r;
    @(posedge clk_in);
    #1 sfr_wr_in = 0;
    sfr_rd_in = 0;
  endtask
  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task give_verdict();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #20000 n_errors++;
    give_verdict();
  end
  initial begin
    int k;
    repeat (20) @(posedge clk_in);
    #1 rst_n_in = 1;
    foreach (rows[i]) begin
      bus(rows[i][19:12], 1, 0);
      bus(8'h00, 0, 1);
      chk("rdata", sfr_rdata_out, rows[i][11:4]);
      chk("select", {7'h00, sfr_sel_out}, 8'h01);
      chk("fields", {2'h0, ext_osc_mode_select_out, ext_osc_range_control_out},
          {2'h0, rows[i][18:16], rows[i][14:12]});
      chk("enables", {5'h00, osc_enable_out, crystal_drive_en_out, div2_en_out},
          {4'h0, rows[i][3:0]});
    end
    $display("test done: modes");
    rst_n_in = 0;
    repeat (2) @(posedge clk_in);
    #1 rst_n_in = 1;
    sfr_page_in = 8'h0E;
    bus(8'h55, 1, 0);
    chk("select", {7'h00, sfr_sel_out}, 8'h00);
    sfr_page_in = 8'h0F;
    sfr_addr_in = 8'h9E;
    bus(8'h55, 1, 0);
    sfr_addr_in = 8'h9F;
    bus(8'h00, 0, 1);
    chk("rdata", sfr_rdata_out, 8'h00);
    bus(8'h44, 1, 1);
    chk("rdata", sfr_rdata_out, 8'h00);
    bus(8'h00, 0, 1);
    chk("rdata", sfr_rdata_out, 8'h44);
    $display("test done: decode");
    // Scaled settle wait; full 64 edges would dominate the run
    bus(8'h67, 1, 0);
    repeat (20) @(posedge clk_in);
    for (k = 0; k < 100 && sfr_rdata_out[7] !== 1'b1; k++) bus(8'h00, 0, 1);
    chk("rdata", sfr_rdata_out, 8'hE7);
    chk("valid", {7'h00, crystal_valid_flag_out}, 8'h01);
    bus(8'h60, 1, 0);
    bus(8'h00, 0, 1);
    chk("rdata", sfr_rdata_out, 8'hE0);
    bus(8'h47, 1, 0);
    bus(8'h00, 0, 1);
    bus(8'h00, 0, 1);
    chk("rdata", sfr_rdata_out, 8'h47);
    chk("valid", {7'h00, crystal_valid_flag_out}, 8'h00);
    $display("test done: crystal");
    give_verdict();
  end
endmodule
`default_nettype wire

// file: testbench/xtal_model.sv
`timescale 1ns/10ps
`default_nettype none
module xtal_model (
  // Drive
  input  wire logic drive_en_in,
  // Crystal node
  output logic      pin_out
);
  // Still while undriven, so no stray edges count
  initial begin
    pin_out = 1'b0;
    forever #40 pin_out = drive_en_in ? ~pin_out : 1'b0;
  end
endmodule
`default_nettype wire

// file: verilog/ext_osc_pkg.sv
package ext_osc_pkg;
  // Register decode
  localparam logic [7:0] OSC_CTRL_ADDR    = 8'h9F;
  localparam logic [7:0] OSC_CTRL_PAGE    = 8'h0F;
  localparam logic [7:0] OSC_CTRL_RESET   = 8'h00;
  // Field positions
  localparam int VALID_BIT      = 7;
  localparam int MODE_MSB       = 6;
  localparam int MODE_LSB       = 4;
  localparam int UNUSED_BIT     = 3;
  localparam int RANGE_MSB      = 2;
  localparam int RANGE_LSB      = 0;
  // Mode select codes
  localparam logic [2:0] MODE_OFF0      = 3'h0;
  localparam logic [2:0] MODE_OFF1      = 3'h1;
  localparam logic [2:0] MODE_CMOS      = 3'h2;
  localparam logic [2:0] MODE_CMOS_DIV2 = 3'h3;
  localparam logic [2:0] MODE_RC        = 3'h4;
  localparam logic [2:0] MODE_CAP       = 3'h5;
  localparam logic [2:0] MODE_XTAL      = 3'h6;
  localparam logic [2:0] MODE_XTAL_DIV2 = 3'h7;
  // Stability detection: edges of the crystal input needed before valid
  localparam int XTAL_STABLE_EDGES = 64;
  localparam int STABLE_CNT_W      = 8;
endpackage

// file: verilog/external_oscillator_control.sv
`timescale 1ns/10ps
`default_nettype none
module external_oscillator_control
  import ext_osc_pkg::*;
#(
  parameter int STABLE_EDGES = XTAL_STABLE_EDGES
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Special-function register port
  input  wire logic [7:0] sfr_page_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic       sfr_wr_in,
  input  wire logic       sfr_rd_in,
  input  wire logic [7:0] sfr_wdata_in,
  output logic      [7:0] sfr_rdata_out,
  output logic            sfr_sel_out,
  // Oscillator pin side
  input  wire logic       crystal_input_pin_in,
  // Analog drive controls
  output logic      [2:0] ext_osc_mode_select_out,
  output logic      [2:0] ext_osc_range_control_out,
  output logic            osc_enable_out,
  output logic            crystal_drive_en_out,
  output logic            div2_en_out,
  output logic            crystal_valid_flag_out
);
  typedef enum logic [2:0] {
    XS_OFF     = 3'b001,
    XS_SETTLE  = 3'b010,
    XS_VALID   = 3'b100
  } xtal_state_t;

  logic [2:0]  mode_ff;
  logic [2:0]  nxt_mode;
  logic [2:0]  range_ff;
  logic [2:0]  nxt_range;
  logic [7:0]  rdata_ff;
  logic [7:0]  nxt_rdata;
  logic        sel_ff;
  logic        nxt_sel;
  xtal_state_t state_ff;
  xtal_state_t nxt_state;
  logic        osc_en_ff;
  logic        nxt_osc_en;
  logic        xtal_en_ff;
  logic        nxt_xtal_en;
  logic        div2_ff;
  logic        nxt_div2;
  logic        valid_ff;
  logic        nxt_valid;
  logic        hit;
  logic        wr_hit;
  logic        rd_hit;
  logic        xtal_mode;
  logic        stable;

  function automatic logic is_xtal(input logic [2:0] m);
    return m[2:1] == MODE_XTAL[2:1];
  endfunction

  function automatic logic is_off(input logic [2:0] m);
    return m[2:1] == MODE_OFF0[2:1];
  endfunction

  function automatic logic is_div2(input logic [2:0] m);
    return (m == MODE_CMOS_DIV2) || (m == MODE_XTAL_DIV2);
  endfunction

  // Unused bit reads zero whatever was written to it
  function automatic logic [7:0] read_image(input logic       valid,
                                            input logic [2:0] mode,
                                            input logic [2:0] range);
    logic [7:0] img;
    img                      = OSC_CTRL_RESET;
    img[VALID_BIT]           = valid;
    img[MODE_MSB:MODE_LSB]   = mode;
    img[UNUSED_BIT]          = 1'b0;
    img[RANGE_MSB:RANGE_LSB] = range;
    return img;
  endfunction

  osc_edge_counter #(
    .STABLE_EDGES (STABLE_EDGES)
  ) u_stable (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .enable_in  (xtal_mode),
    .osc_in     (crystal_input_pin_in),
    .stable_out (stable)
  );

  // Page and address come from the core on this clock, no synchroniser
  assign hit       = (sfr_addr_in == OSC_CTRL_ADDR) && (sfr_page_in == OSC_CTRL_PAGE);
  assign wr_hit    = hit && sfr_wr_in;
  assign rd_hit    = hit && sfr_rd_in;
  assign xtal_mode = is_xtal(mode_ff);

  // Bits 7 and 3 of a write are dropped
  always_comb begin
    nxt_mode  = mode_ff;
    nxt_range = range_ff;
    if (wr_hit) begin
      nxt_mode  = sfr_wdata_in[MODE_MSB:MODE_LSB];
      nxt_range = sfr_wdata_in[RANGE_MSB:RANGE_LSB];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mode_ff  <= OSC_CTRL_RESET[MODE_MSB:MODE_LSB];
      range_ff <= OSC_CTRL_RESET[RANGE_MSB:RANGE_LSB];
    end else begin
      mode_ff  <= nxt_mode;
      range_ff <= nxt_range;
    end
  end

  // Image built from old fields, so a read beside a write returns the old value
  always_comb begin
    nxt_sel   = rd_hit || wr_hit;
    nxt_rdata = rdata_ff;
    if (rd_hit) begin
      nxt_rdata = read_image(valid_ff, mode_ff, range_ff);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_ff <= OSC_CTRL_RESET;
      sel_ff   <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      sel_ff   <= nxt_sel;
    end
  end

  // Valid only after settle; software must still wait its own delay
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      XS_OFF:    if (is_xtal(mode_ff)) nxt_state = XS_SETTLE;
      XS_SETTLE: begin
        if (!is_xtal(mode_ff)) nxt_state = XS_OFF;
        else if (stable) nxt_state = XS_VALID;
      end
      XS_VALID:  if (!is_xtal(mode_ff) || !stable) nxt_state = XS_OFF;
      default:   nxt_state = XS_OFF;
    endcase
    nxt_valid = (nxt_state == XS_VALID);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_ff <= XS_OFF;
      valid_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      valid_ff <= nxt_valid;
    end
  end

  // Drive enables lag the mode field by one cycle
  always_comb begin
    nxt_osc_en  = !is_off(mode_ff);
    nxt_xtal_en = xtal_mode;
    nxt_div2    = is_div2(mode_ff);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      osc_en_ff  <= 1'b0;
      xtal_en_ff <= 1'b0;
      div2_ff    <= 1'b0;
    end else begin
      osc_en_ff  <= nxt_osc_en;
      xtal_en_ff <= nxt_xtal_en;
      div2_ff    <= nxt_div2;
    end
  end

  assign sfr_rdata_out             = rdata_ff;
  assign sfr_sel_out               = sel_ff;
  assign ext_osc_mode_select_out   = mode_ff;
  assign ext_osc_range_control_out = range_ff;
  assign osc_enable_out            = osc_en_ff;
  assign crystal_drive_en_out      = xtal_en_ff;
  assign div2_en_out               = div2_ff;
  assign crystal_valid_flag_out    = valid_ff;
endmodule
`default_nettype wire

// file: verilog/osc_edge_counter.sv
`timescale 1ns/10ps
`default_nettype none
module osc_edge_counter
  import ext_osc_pkg::*;
#(
  parameter int STABLE_EDGES = XTAL_STABLE_EDGES
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Control
  input  wire logic enable_in,
  input  wire logic osc_in,
  // Status
  output logic      stable_out
);
  logic                    sync1_ff;
  logic                    sync2_ff;
  logic                    prev_ff;
  logic [STABLE_CNT_W-1:0] cnt_ff;
  logic [STABLE_CNT_W-1:0] nxt_cnt;
  logic                    stable_ff;
  logic                    nxt_stable;

  always_comb begin
    nxt_cnt    = cnt_ff;
    nxt_stable = stable_ff;
    if (!enable_in) begin
      nxt_cnt    = '0;
      nxt_stable = 1'b0;
    end else if (sync2_ff && !prev_ff && !stable_ff) begin
      if (cnt_ff == STABLE_CNT_W'(STABLE_EDGES - 1)) begin
        nxt_stable = 1'b1;
      end
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  // Pin is asynchronous, two stages before use
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync1_ff  <= 1'b0;
      sync2_ff  <= 1'b0;
      prev_ff   <= 1'b0;
      cnt_ff    <= '0;
      stable_ff <= 1'b0;
    end else begin
      sync1_ff  <= osc_in;
      sync2_ff  <= sync1_ff;
      prev_ff   <= sync2_ff;
      cnt_ff    <= nxt_cnt;
      stable_ff <= nxt_stable;
    end
  end

  assign stable_out = stable_ff;
endmodule
`default_nettype wire
